// ==== ssf_consts.svh ====
// Constants of the serial status flag block: offsets, bit positions, resets.
// Included by the package and design files by bare name.
`ifndef SSF_CONSTS_SVH
`define SSF_CONSTS_SVH

`define SSF_ADR_W 8
`define SSF_ADR_STATUS 2'h0
`define SSF_ADR_TXBUF 2'h1
`define SSF_ADR_RXBUF 2'h2
`define SSF_ADR_CTRL 2'h3

`define SSF_STATUS_RST 8'h84
`define SSF_CTRL_RST 8'h00
`define SSF_BYTE_RST 8'h00

`define SSF_B_TX_BUFFER_EMPTY 7
`define SSF_B_RX_BUFFER_FULL 6
`define SSF_B_OER 5
`define SSF_B_FER 4
`define SSF_B_PER 3
`define SSF_B_TX_END 2
`define SSF_B_RX_MULTIPROC_BIT 1
`define SSF_B_TX_MULTIPROC_BIT 0
`define SSF_B_CLR_LO 3

`define SSF_C_SYNC 7
`define SSF_C_TXEN 5
`define SSF_C_RXEN 4
`define SSF_C_PEN 3
`define SSF_C_PODD 2
`define SSF_C_MPEN 1

`endif

// ==== ssf_pkg.sv ====
// Types shared by the serial status flag block.
// Assumes ssf_consts.svh is on the include path.
`include "ssf_consts.svh"
package ssf_pkg;
	typedef struct packed {
		logic [7:0] data;
		logic mp;
		logic par;
		logic stop1;
	} ssf_rx_char_t;

	typedef struct packed {
		logic cyc;
		logic stb;
		logic we;
		logic [`SSF_ADR_W-1:0] adr;
		logic [3:0] sel;
		logic [31:0] dat;
	} ssf_wb_req_t;

	typedef struct packed {
		logic ack;
		logic [31:0] dat;
	} ssf_bus_t;

	typedef struct packed {
		logic [7:0] st;
		logic [7:0] ctrl;
		logic [7:0] txbuf;
		logic [7:0] rxbuf;
		logic [4:0] armed;
		logic rx_halt;
		logic tx_halt;
	} ssf_core_t;
endpackage

// ==== ssf_rx_check.sv ====
// Frame check of one received character: stop bit and parity.
// Pure combinational; the caller samples it on the completion pulse.
`timescale 1ns/1ns
`include "ssf_consts.svh"
module ssf_rx_check (
	input wire ssf_pkg::ssf_rx_char_t char_i,
	input wire logic async_i,
	input wire logic parity_en_i,
	input wire logic parity_odd_i,
	output logic framing_o,
	output logic parity_o
);
	// Second stop bit never reaches this block, so it is never judged
	assign framing_o = async_i & ~char_i.stop1; // [R13] [R14]
	// Odd parity wants an odd count of ones over data plus parity bit
	assign parity_o = async_i & parity_en_i
		& ((^{char_i.data, char_i.par}) != parity_odd_i); // [R17]
endmodule

// ==== ssf_bus_port.sv ====
// Classic Wishbone slave front end: decode, one-wait-state ack, read latch.
// Assumes a single-cycle classic master on the same clock.
`timescale 1ns/1ns
`include "ssf_consts.svh"
module ssf_bus_port (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire ssf_pkg::ssf_wb_req_t req_i,
	input wire logic [7:0] rd_value_i,
	output logic [1:0] idx_o,
	output logic rd_o,
	output logic wr_o,
	output logic ack_o,
	output logic [31:0] dat_o
);
	ssf_pkg::ssf_bus_t s;
	ssf_pkg::ssf_bus_t next_s;
	logic access;
	logic hit;

	assign access = req_i.cyc & req_i.stb & ~s.ack;
	// Upper address bits must be zero; other addresses answer zero
	assign hit = (req_i.adr[`SSF_ADR_W-1:4] == '0) & (req_i.adr[1:0] == 2'h0);
	assign idx_o = req_i.adr[3:2];
	assign rd_o = access & hit & ~req_i.we;
	// Registers are one byte wide; lane 0 must be selected
	assign wr_o = access & hit & req_i.we & req_i.sel[0];
	assign ack_o = s.ack;
	assign dat_o = s.dat;

	always_comb begin
		next_s = s;
		next_s.ack = access;
		if (access) begin
			next_s.dat = {24'h000000, (rd_o ? rd_value_i : 8'h00)};
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end
endmodule

// ==== ssf_status.sv ====
// Status flag register of a serial unit with its transmit and receive buffers.
// Event inputs come from transmit/receive logic on clk_i and are one-cycle pulses.
//
// Operation
// [R01] Status returns to 84h at reset and on standby or watch entry.
// [R02] Clearable flags drop only on write 0 after being read as 1.
// [R03] Transmit-end and received multiprocessor bit ignore software writes.
// [R04] Buffer-empty sets when a character moves into the shift register.
// [R05] Clearing transmitter enable also sets buffer-empty.
// [R06] Writing the transmit buffer clears buffer-empty.
// [R07] Clean reception into the receive buffer sets buffer-full.
// [R08] Reading the receive buffer clears buffer-full.
// [R09] Receive error or disabled receiver leaves buffer and full flag alone.
// [R10] Reception while full sets overrun and drops the new character.
// [R11] Overrun halts reception, and transmission too in synchronous mode.
// [R12] Clearing receiver enable keeps overrun and framing flags unchanged.
// [R13] Asynchronous stop bit sampled 0 sets framing error.
// [R14] With two stop bits only the first is checked.
// [R15] Framing error still stores the character but not buffer-full.
// [R16] Framing error halts reception; synchronous mode halts both directions.
// [R17] Parity mismatch in asynchronous parity mode sets parity error.
// [R18] Transmit-end sets on last bit with buffer empty; clears like it.
// [R19] Received multiprocessor bit stored; transmit multiprocessor bit sent.
// [R20] Writing 1, or 0 without prior read of 1, leaves flags unchanged.
//
// Chosen here: the Wishbone register port and the register offsets.
`timescale 1ns/1ns
`include "ssf_consts.svh"
module ssf_status (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [`SSF_ADR_W-1:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic low_power_i,
	input wire logic tx_load_i,
	input wire logic tx_last_bit_i,
	input wire logic rx_done_i,
	input wire ssf_pkg::ssf_rx_char_t rx_char_i,
	output logic [7:0] serial_status_o,
	output logic [7:0] tx_data_o,
	output logic tx_multiproc_bit_o,
	output logic tx_enable_o,
	output logic rx_enable_o,
	output logic sync_mode_o,
	output logic rx_halt_o,
	output logic tx_halt_o
);
	ssf_pkg::ssf_core_t s;
	ssf_pkg::ssf_core_t next_s;
	ssf_pkg::ssf_wb_req_t req;
	logic [1:0] idx;
	logic bus_rd;
	logic bus_wr;
	logic [7:0] wdat;
	logic [7:0] rd_value;
	logic wr_status;
	logic wr_txbuf;
	logic wr_ctrl;
	logic rd_status;
	logic rd_rxbuf;
	logic rx_framing;
	logic rx_parity;
	logic rx_accept;

	assign req = '{cyc: wb_cyc_i, stb: wb_stb_i, we: wb_we_i, adr: wb_adr_i,
		sel: wb_sel_i, dat: wb_dat_i};
	assign wdat = wb_dat_i[7:0];

	ssf_bus_port u_bus (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.req_i(req),
		.rd_value_i(rd_value),
		.idx_o(idx),
		.rd_o(bus_rd),
		.wr_o(bus_wr),
		.ack_o(wb_ack_o),
		.dat_o(wb_dat_o)
	);

	ssf_rx_check u_chk (
		.char_i(rx_char_i),
		.async_i(~s.ctrl[`SSF_C_SYNC]),
		.parity_en_i(s.ctrl[`SSF_C_PEN]),
		.parity_odd_i(s.ctrl[`SSF_C_PODD]),
		.framing_o(rx_framing),
		.parity_o(rx_parity)
	);

	function automatic logic is_reg(input logic [1:0] a, input logic [1:0] b);
		is_reg = (a == b);
	endfunction

	assign wr_status = bus_wr & is_reg(idx, `SSF_ADR_STATUS);
	assign wr_txbuf = bus_wr & is_reg(idx, `SSF_ADR_TXBUF);
	assign wr_ctrl = bus_wr & is_reg(idx, `SSF_ADR_CTRL);
	assign rd_status = bus_rd & is_reg(idx, `SSF_ADR_STATUS);
	assign rd_rxbuf = bus_rd & is_reg(idx, `SSF_ADR_RXBUF);

	// Completion pulses are dropped while disabled or halted
	assign rx_accept = rx_done_i & s.ctrl[`SSF_C_RXEN] & ~s.rx_halt; // [R09] [R12] [R16]

	always_comb begin
		case (idx)
			`SSF_ADR_STATUS: rd_value = s.st;
			`SSF_ADR_TXBUF: rd_value = s.txbuf;
			`SSF_ADR_RXBUF: rd_value = s.rxbuf;
			`SSF_ADR_CTRL: rd_value = s.ctrl;
			default: rd_value = 8'h00;
		endcase
	end

	always_comb begin
		next_s = s;
		// Software side first, so hardware sets below win a same-cycle clear
		if (wr_ctrl) begin
			next_s.ctrl = wdat;
		end
		if (wr_txbuf) begin
			next_s.txbuf = wdat;
			next_s.st[`SSF_B_TX_BUFFER_EMPTY] = 1'b0; // [R06]
			next_s.st[`SSF_B_TX_END] = 1'b0; // [R18]
		end
		if (wr_status) begin
			// Transmit-end and received multiprocessor bit are not written
			next_s.st[`SSF_B_TX_MULTIPROC_BIT] = wdat[`SSF_B_TX_MULTIPROC_BIT]; // [R03] [R19]
			for (int k = `SSF_B_CLR_LO; k <= `SSF_B_TX_BUFFER_EMPTY; k++) begin
				// A 1 or an unarmed 0 leaves the flag alone
				if (!wdat[k] && s.armed[k - `SSF_B_CLR_LO] && s.st[k]) begin // [R02] [R20]
					next_s.st[k] = 1'b0;
				end
			end
			if (!wdat[`SSF_B_TX_BUFFER_EMPTY] && s.armed[4] && s.st[`SSF_B_TX_BUFFER_EMPTY]) begin
				next_s.st[`SSF_B_TX_END] = 1'b0; // [R18]
			end
			next_s.armed = 5'h00;
		end
		if (rd_status) begin
			// Remember which flags software has seen as 1
			next_s.armed = s.st[`SSF_B_TX_BUFFER_EMPTY:`SSF_B_CLR_LO]; // [R02]
		end
		if (rd_rxbuf) begin
			next_s.st[`SSF_B_RX_BUFFER_FULL] = 1'b0; // [R08]
		end
		// Transmit events
		if (tx_load_i) begin
			next_s.st[`SSF_B_TX_BUFFER_EMPTY] = 1'b1; // [R04]
		end
		if (wr_ctrl && !wdat[`SSF_C_TXEN]) begin
			next_s.st[`SSF_B_TX_BUFFER_EMPTY] = 1'b1; // [R05]
			next_s.st[`SSF_B_TX_END] = 1'b1; // [R18]
		end
		if (tx_last_bit_i && s.st[`SSF_B_TX_BUFFER_EMPTY]) begin
			next_s.st[`SSF_B_TX_END] = 1'b1; // [R18]
		end
		// Receive events
		if (rx_accept) begin
			if (s.st[`SSF_B_RX_BUFFER_FULL]) begin
				// Old character kept, new one lost
				next_s.st[`SSF_B_OER] = 1'b1; // [R10]
			end else begin
				next_s.rxbuf = rx_char_i.data; // [R15]
				if (rx_framing) begin
					next_s.st[`SSF_B_FER] = 1'b1; // [R13]
				end
				if (rx_parity) begin
					next_s.st[`SSF_B_PER] = 1'b1; // [R17]
				end
				if (!rx_framing && !rx_parity) begin
					next_s.st[`SSF_B_RX_BUFFER_FULL] = 1'b1; // [R07]
				end
				if (s.ctrl[`SSF_C_MPEN] && !s.ctrl[`SSF_C_SYNC]) begin
					next_s.st[`SSF_B_RX_MULTIPROC_BIT] = rx_char_i.mp; // [R19]
				end
			end
		end
		if (low_power_i) begin
			next_s.st = `SSF_STATUS_RST; // [R01]
			next_s.armed = 5'h00;
		end
		// Halts are registered so they reach the ports with the flags
		next_s.rx_halt = next_s.st[`SSF_B_OER] | next_s.st[`SSF_B_FER]
			| next_s.st[`SSF_B_PER]; // [R11] [R16]
		next_s.tx_halt = next_s.ctrl[`SSF_C_SYNC]
			& (next_s.st[`SSF_B_OER] | next_s.st[`SSF_B_FER]); // [R11] [R16]
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s.st <= `SSF_STATUS_RST; // [R01]
			s.ctrl <= `SSF_CTRL_RST;
			s.txbuf <= `SSF_BYTE_RST;
			s.rxbuf <= `SSF_BYTE_RST;
			s.armed <= 5'h00;
			s.rx_halt <= 1'b0;
			s.tx_halt <= 1'b0;
		end else begin
			s <= next_s;
		end
	end

	assign serial_status_o = s.st;
	assign tx_data_o = s.txbuf;
	assign tx_multiproc_bit_o = s.st[`SSF_B_TX_MULTIPROC_BIT]; // [R19]
	assign tx_enable_o = s.ctrl[`SSF_C_TXEN];
	assign rx_enable_o = s.ctrl[`SSF_C_RXEN];
	assign sync_mode_o = s.ctrl[`SSF_C_SYNC];
	assign rx_halt_o = s.rx_halt;
	assign tx_halt_o = s.tx_halt;

	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);

	low_power_reset_a: assert property ( // [R01]
		low_power_i |=> (serial_status_o == `SSF_STATUS_RST) && !rx_halt_o)
		else $error("status not 84h after low-power entry");

	armed_clear_a: assert property ( // [R02]
		wr_status && !wdat[`SSF_B_OER] && s.armed[2] && serial_status_o[`SSF_B_OER]
		|=> !serial_status_o[`SSF_B_OER])
		else $error("overrun not cleared by armed write of 0");

	unarmed_write_a: assert property ( // [R20]
		wr_status && s.armed == 5'h00 && !tx_load_i && !rx_done_i && !low_power_i
		|=> $stable(serial_status_o[7:3]))
		else $error("flag changed by unarmed status write");

	rx_multiproc_bit_readonly_a: assert property ( // [R03]
		wr_status && !rx_done_i && !low_power_i |=> $stable(serial_status_o[1]))
		else $error("received multiprocessor bit changed by write");

	load_sets_empty_a: assert property ( // [R04]
		tx_load_i |=> serial_status_o[`SSF_B_TX_BUFFER_EMPTY])
		else $error("empty flag not set on load");

	txbuf_write_a: assert property ( // [R06]
		wr_txbuf && !tx_load_i && !low_power_i
		|=> !serial_status_o[`SSF_B_TX_BUFFER_EMPTY] && !serial_status_o[`SSF_B_TX_END]
		&& tx_data_o == $past(wdat))
		else $error("transmit buffer write did not clear flags");

	rxbuf_read_a: assert property ( // [R08]
		rd_rxbuf && !rx_accept && !low_power_i |=> !serial_status_o[`SSF_B_RX_BUFFER_FULL])
		else $error("full flag not cleared on buffer read");

	overrun_keep_a: assert property ( // [R10]
		rx_accept && serial_status_o[`SSF_B_RX_BUFFER_FULL] && !low_power_i
		|=> serial_status_o[`SSF_B_OER] && $stable(s.rxbuf) && rx_halt_o)
		else $error("overrun did not keep buffer or halt");

	framing_store_a: assert property ( // [R15]
		rx_accept && rx_framing && !serial_status_o[`SSF_B_RX_BUFFER_FULL] && !low_power_i
		|=> serial_status_o[`SSF_B_FER] && !serial_status_o[`SSF_B_RX_BUFFER_FULL]
		&& s.rxbuf == $past(rx_char_i.data))
		else $error("framing error handling wrong");

	disabled_hold_a: assert property ( // [R09]
		rx_done_i && !rx_enable_o && !wr_status && !rd_rxbuf && !low_power_i
		|=> $stable(s.rxbuf) && $stable(serial_status_o[6:4]))
		else $error("disabled receiver changed buffer or flags");

	tx_end_readonly_a: assert property ( // [R03]
		wr_status && wdat[`SSF_B_TX_BUFFER_EMPTY] && !tx_last_bit_i && !low_power_i
		|=> $stable(serial_status_o[`SSF_B_TX_END]))
		else $error("transmit end changed by status write");

	txen_clear_a: assert property ( // [R05]
		wr_ctrl && !wdat[`SSF_C_TXEN]
		|=> serial_status_o[`SSF_B_TX_BUFFER_EMPTY] && serial_status_o[`SSF_B_TX_END])
		else $error("transmitter disable did not set empty and end");

	clean_rx_full_a: assert property ( // [R07]
		rx_accept && rx_char_i.stop1 && !s.ctrl[`SSF_C_PEN]
		&& !serial_status_o[`SSF_B_RX_BUFFER_FULL] && !low_power_i
		|=> serial_status_o[`SSF_B_RX_BUFFER_FULL] && s.rxbuf == $past(rx_char_i.data))
		else $error("clean reception did not fill the buffer");

	halted_rx_a: assert property ( // [R11] [R16]
		rx_done_i && rx_halt_o && !wr_status && !rd_rxbuf && !low_power_i
		|=> $stable(s.rxbuf) && $stable(serial_status_o[6:3]))
		else $error("reception went on while halted");

	error_halts_a: assert property ( // [R11] [R16]
		serial_status_o[`SSF_B_OER] || serial_status_o[`SSF_B_FER]
		|-> rx_halt_o && tx_halt_o == sync_mode_o)
		else $error("error flag without matching halt");

	rxen_clear_keep_a: assert property ( // [R12]
		wr_ctrl && !wdat[`SSF_C_RXEN] && !rx_done_i && !low_power_i
		|=> $stable(serial_status_o[5:3]))
		else $error("receiver disable changed error flags");

	stop_zero_a: assert property ( // [R13]
		rx_accept && !sync_mode_o && !rx_char_i.stop1
		&& !serial_status_o[`SSF_B_RX_BUFFER_FULL] && !low_power_i
		|=> serial_status_o[`SSF_B_FER])
		else $error("stop bit 0 did not set framing error");

	parity_flag_a: assert property ( // [R17]
		rx_accept && !sync_mode_o && s.ctrl[`SSF_C_PEN]
		&& !serial_status_o[`SSF_B_RX_BUFFER_FULL] && !low_power_i
		&& ((^rx_char_i.data ^ rx_char_i.par) != s.ctrl[`SSF_C_PODD])
		|=> serial_status_o[`SSF_B_PER] && !serial_status_o[`SSF_B_RX_BUFFER_FULL])
		else $error("parity mismatch not flagged");

	last_bit_end_a: assert property ( // [R18]
		tx_last_bit_i && serial_status_o[`SSF_B_TX_BUFFER_EMPTY] |=> serial_status_o[`SSF_B_TX_END])
		else $error("transmit end not set after last bit");

	busy_no_end_a: assert property ( // [R18]
		tx_last_bit_i && !serial_status_o[`SSF_B_TX_BUFFER_EMPTY] && !serial_status_o[`SSF_B_TX_END]
		&& !wr_ctrl && !low_power_i
		|=> !serial_status_o[`SSF_B_TX_END])
		else $error("transmit end set while buffer still full");

	mp_bit_store_a: assert property ( // [R19]
		rx_accept && s.ctrl[`SSF_C_MPEN] && !sync_mode_o
		&& !serial_status_o[`SSF_B_RX_BUFFER_FULL] && !low_power_i
		|=> serial_status_o[`SSF_B_RX_MULTIPROC_BIT] == $past(rx_char_i.mp))
		else $error("received multiprocessor bit not stored");

	mp_bit_send_a: assert property ( // [R19]
		wr_status && !low_power_i
		|=> tx_multiproc_bit_o == $past(wdat[`SSF_B_TX_MULTIPROC_BIT]))
		else $error("transmit multiprocessor bit not written");

	write_one_keep_a: assert property ( // [R20]
		wr_status && (&wdat[`SSF_B_TX_BUFFER_EMPTY:`SSF_B_CLR_LO]) && !tx_load_i && !rx_done_i
		&& !low_power_i |=> $stable(serial_status_o[7:3]))
		else $error("writing 1 changed a clearable flag");

	ack_follows_a: assert property (
		wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("bus request not answered next cycle");

	ack_pulse_a: assert property (
		wb_ack_o |=> !wb_ack_o)
		else $error("bus ack stood longer than one cycle");
endmodule

// ==== ssf_peer.sv ====
// Far-side model: event source of the serial line for the status block.
// Assumes its tasks are called from one bench process, all on clk_i.
`timescale 1ns/1ns
module ssf_peer (
	input wire logic clk_i,
	output logic tx_load_o,
	output logic tx_last_bit_o,
	output logic rx_done_o,
	output ssf_pkg::ssf_rx_char_t rx_char_o
);
	initial begin
		tx_load_o = 1'b0;
		tx_last_bit_o = 1'b0;
		rx_done_o = 1'b0;
		rx_char_o = '0;
	end
	// Character is valid only with the pulse; inverted after it so no stale match
	task rx(input logic [7:0] d, input logic mp, input logic par, input logic stop);
		@(posedge clk_i);
		rx_done_o <= 1'b1;
		rx_char_o <= {d, mp, par, stop};
		@(posedge clk_i);
		rx_done_o <= 1'b0;
		rx_char_o <= ~{d, mp, par, stop};
	endtask
	task tx(input logic load, input logic last);
		@(posedge clk_i);
		tx_load_o <= load;
		tx_last_bit_o <= last;
		@(posedge clk_i);
		tx_load_o <= 1'b0;
		tx_last_bit_o <= 1'b0;
	endtask
endmodule

// ==== tb_serial_status_flags.sv ====
// Self-checking bench of the status flag block over classic Wishbone.
// Assumes ssf_pkg and ssf_peer are compiled first.
`timescale 1ns/1ns
module tb_serial_status_flags;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic cyc = 1'b0;
	logic stb = 1'b0;
	logic we = 1'b0;
	logic lp = 1'b0;
	logic [7:0] adr = 8'h00;
	logic [31:0] dat = 32'h0;
	logic [3:0] sel = 4'h0;
	logic [31:0] rdo;
	logic ack, tld, tlb, rxd, rxh, txh, tmp, ten, ren, syn;
	logic [7:0] sts, tdo, rdat;
	ssf_pkg::ssf_rx_char_t rch;
	int n_fail = 0;
	int n_compared = 0;
	int cycles = 0;
	always #4 clk_i = ~clk_i;
	ssf_peer peer (.clk_i(clk_i), .tx_load_o(tld), .tx_last_bit_o(tlb), .rx_done_o(rxd),
		.rx_char_o(rch));
	ssf_status dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rdo),
		.wb_ack_o(ack), .low_power_i(lp), .tx_load_i(tld), .tx_last_bit_i(tlb),
		.rx_done_i(rxd), .rx_char_i(rch), .serial_status_o(sts), .tx_data_o(tdo),
		.tx_multiproc_bit_o(tmp), .tx_enable_o(ten), .rx_enable_o(ren),
		.sync_mode_o(syn),
		.rx_halt_o(rxh), .tx_halt_o(txh));
	task give_verdict;
		$display("compared %0d failed %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	// Hang guard, far above the roughly 120 cycles the sequence needs
	always @(posedge clk_i) begin
		cycles <= cycles + 1;
		if (cycles == 5000) begin
			n_fail++;
			give_verdict();
		end
	end
	task chk(input logic [7:0] got, input logic [7:0] exp);
		n_compared++;
		if (got !== exp) begin
			n_fail++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task bus(input logic [7:0] a, input logic w, input logic [7:0] d);
		@(posedge clk_i);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		dat <= {24'h0, d};
		sel <= 4'hF;
		do @(posedge clk_i); while (ack !== 1'b1);
		rdat = rdo[7:0];
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
	endtask
	task rd(input logic [7:0] a, input logic [7:0] e);
		bus(a, 1'b0, 8'h00);
		chk(rdat, e);
		chk({7'h0, |rdo[31:8]}, 8'h00);
	endtask
	// Flags update on the edge, so look half a cycle later
	task st(input logic [7:0] e);
		@(negedge clk_i);
		chk(sts, e);
	endtask
	initial begin
		repeat (3) @(posedge clk_i);
		rst_i <= 1'b0;
		st(8'h84);
		rd(8'h0C, 8'h00);
		bus(8'h00, 1'b1, 8'h00);
		st(8'h84);
		$display("test reset done");
		bus(8'h0C, 1'b1, 8'h30);
		bus(8'h04, 1'b1, 8'h5A);
		st(8'h00);
		chk(tdo, 8'h5A);
		peer.tx(1'b0, 1'b1);
		st(8'h00);
		peer.tx(1'b1, 1'b0);
		st(8'h80);
		peer.tx(1'b0, 1'b1);
		st(8'h84);
		bus(8'h00, 1'b1, 8'hFB);
		st(8'h85);
		chk({7'h0, tmp}, 8'h01);
		rd(8'h00, 8'h85);
		bus(8'h00, 1'b1, 8'h00);
		st(8'h00);
		bus(8'h0C, 1'b1, 8'h10);
		st(8'h84);
		bus(8'h0C, 1'b1, 8'h30);
		rd(8'h00, 8'h84);
		bus(8'h40, 1'b1, 8'h00);
		st(8'h84);
		rd(8'h10, 8'h00);
		$display("test transmit done");
		peer.rx(8'h3C, 1'b0, 1'b0, 1'b1);
		st(8'hC4);
		rd(8'h08, 8'h3C);
		st(8'h84);
		bus(8'h0C, 1'b1, 8'hB0);
		chk({5'h0, syn, ten, ren}, 8'h07);
		peer.rx(8'h11, 1'b0, 1'b0, 1'b1);
		peer.rx(8'h22, 1'b0, 1'b0, 1'b1);
		st(8'hE4);
		chk({6'h0, rxh, txh}, 8'h03);
		peer.rx(8'h33, 1'b0, 1'b0, 1'b1);
		rd(8'h08, 8'h11);
		rd(8'h00, 8'hA4);
		bus(8'h00, 1'b1, 8'h80);
		st(8'h84);
		chk({6'h0, rxh, txh}, 8'h00);
		$display("test overrun done");
		bus(8'h0C, 1'b1, 8'h30);
		peer.rx(8'h55, 1'b0, 1'b0, 1'b0);
		st(8'h94);
		rd(8'h08, 8'h55);
		chk({6'h0, rxh, txh}, 8'h02);
		bus(8'h0C, 1'b1, 8'h20);
		chk({5'h0, syn, ten, ren}, 8'h02);
		st(8'h94);
		rd(8'h00, 8'h94);
		bus(8'h00, 1'b1, 8'h80);
		st(8'h84);
		peer.rx(8'h66, 1'b0, 1'b0, 1'b1);
		rd(8'h08, 8'h55);
		st(8'h84);
		$display("test framing done");
		bus(8'h0C, 1'b1, 8'h38);
		peer.rx(8'h01, 1'b0, 1'b0, 1'b1);
		st(8'h8C);
		rd(8'h00, 8'h8C);
		bus(8'h00, 1'b1, 8'h80);
		st(8'h84);
		bus(8'h0C, 1'b1, 8'h32);
		peer.rx(8'h7E, 1'b1, 1'b0, 1'b1);
		rd(8'h00, 8'hC6);
		bus(8'h00, 1'b1, 8'hC4);
		st(8'hC6);
		rd(8'h08, 8'h7E);
		bus(8'h04, 1'b1, 8'hA5);
		st(8'h02);
		@(posedge clk_i);
		lp <= 1'b1;
		@(posedge clk_i);
		lp <= 1'b0;
		st(8'h84);
		$display("test parity, multiprocessor and standby done");
		give_verdict();
	end
endmodule
